// >>> verilog/ecer_pkg.sv
package ecer_pkg;

  // ***********************************************************
  // widths and register layout
  // ***********************************************************
  localparam int ECER_ADDR_W = 32;
  localparam int ECER_STAT_W = 8;
  localparam int ECER_TALLY_W = 16;
  localparam logic [7:0] ECER_STAT_RST = 8'h00;
  localparam logic [31:0] ECER_TRAP_RST = 32'h0000_0000;
  localparam logic [15:0] ECER_TALLY_RST = 16'h0000;
  localparam logic [15:0] ECER_TALLY_MAX = 16'hFFFF;
  localparam logic [15:0] ECER_TALLY_ONE = 16'h0001;
  // sticky event bits of the event status register
  localparam int ECER_STAT_SBE_BIT = 3;
  localparam int ECER_STAT_DBE_BIT = 4;
  localparam logic [7:0] ECER_STAT_USED = 8'h18;

  // per-unit status byte
  localparam int ECER_DUS_DBE_BIT = 3;
  localparam int ECER_DUS_SBC_BIT = 1;
  localparam int ECER_DUS_OFF_BIT = 0;
  localparam logic [7:0] ECER_DUS_RST = 8'h00;

  // 16-byte data units, flag memory indexed by low unit bits
  localparam int ECER_UNIT_LO = 4;
  localparam int ECER_IDX_W = 8;
  localparam int ECER_MEM_DEPTH = 256;

  // ***********************************************************
  // serial commands and register addresses (arbitrary values)
  // ***********************************************************
  localparam logic [7:0] ECER_OP_REG_READ = 8'hA1;
  localparam logic [7:0] ECER_OP_UNIT_QUERY = 8'hA2;
  localparam logic [7:0] ECER_OP_CLEAR = 8'hA3;
  localparam logic [31:0] ECER_RA_STATUS = 32'h0000_0100;
  localparam logic [31:0] ECER_RA_TRAP = 32'h0000_0104;
  localparam logic [31:0] ECER_RA_TALLY = 32'h0000_0108;
  localparam logic [5:0] ECER_OP_LAST = 6'd7;
  localparam logic [5:0] ECER_ADDR_LAST = 6'd31;
  localparam logic [5:0] ECER_CNT_ONE = 6'd1;

  // ***********************************************************
  // types
  // ***********************************************************
  typedef enum logic [2:0] {
    ECER_SP_IDLE,
    ECER_SP_OP,
    ECER_SP_ADDR,
    ECER_SP_OUT,
    ECER_SP_WAIT
  } ecer_phase_e;

  // one decoded data unit from the array read engine
  typedef struct packed {
    logic [31:0] addr;
    logic sbe;
    logic dbe;
    logic main_arr;
  } ecer_unit_s;

  // per-unit flags kept in the flag memory
  typedef struct packed {
    logic programmed;
    logic off;
    logic sbe;
    logic dbe;
  } ecer_flags_s;

  typedef struct packed {
    logic [2:0] sck_s;
    logic [2:0] cs_s;
    logic [1:0] si_s;
    ecer_phase_e phase;
    logic [5:0] bit_cnt;
    logic [31:0] sh_in;
    logic [31:0] sh_out;
    logic is_query;
    logic clr_armed;
    logic q_pend;
    logic so;
    logic so_oe_n;
    ecer_unit_s pend;
    logic pend_v;
    logic prog_v;
    logic prog_err;
    logic [7:0] status;
    logic [31:0] trap;
    logic trap_full;
    logic [15:0] tally;
    logic last_v;
    logic [31:0] last_unit;
  } ecer_state_s;

endpackage

// >>> verilog/ecer_unit_mem.sv
`timescale 1ns/1ps
module ecer_unit_mem
  import ecer_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // read port, data registered
  input wire logic rd_en,
  input wire logic [ECER_IDX_W-1:0] rd_idx,
  output ecer_flags_s rd_data,
  // write port
  input wire logic wr_en,
  input wire logic [ECER_IDX_W-1:0] wr_idx,
  input wire ecer_flags_s wr_data
);

  ecer_flags_s mem [ECER_MEM_DEPTH];
  ecer_flags_s rd_reg;

  assign rd_data = rd_reg;

  // ***********************************************************
  // storage; reset leaves every unit erased
  // ***********************************************************
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rd_reg <= '0;
      for (int i = 0; i < ECER_MEM_DEPTH; i++)
      begin
        mem[i] <= '0;
      end
    end
    else
    begin
      if (rd_en)
      begin
        rd_reg <= mem[rd_idx]; // old value on same-cycle write
      end
      if (wr_en)
      begin
        mem[wr_idx] <= wr_data;
      end
    end
  end

endmodule

// >>> verilog/ecer_top.sv
`timescale 1ns/1ps
module ecer_top
  import ecer_pkg::*;
(
  // clock and power-on reset
  input wire logic clk,
  input wire logic rstn,
  // serial host pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe_n,
  // array read engine
  input wire logic arr_rd_active,
  input wire logic unit_valid,
  input wire ecer_unit_s unit_in,
  // program and erase engine
  input wire logic prog_req,
  input wire logic [31:0] prog_addr,
  input wire logic erase_req,
  input wire logic [31:0] erase_addr,
  output logic prog_err,
  // configuration and reset sources
  input wire logic dbl_detect_en,
  input wire logic trap_any_err,
  input wire logic hw_sw_reset,
  input wire logic serial_reset
);

  ecer_state_s s_reg;
  ecer_state_s s_next;
  ecer_flags_s mem_rd;
  ecer_flags_s mem_wd;
  ecer_flags_s f_upd;
  logic mem_re;
  logic mem_we;
  logic [ECER_IDX_W-1:0] mem_ridx;
  logic [ECER_IDX_W-1:0] mem_widx;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic clr_cmd;
  logic clr_any;
  logic e1;
  logic e2;
  logic err;
  logic dup;
  logic [7:0] op;
  logic [31:0] a;
  logic [7:0] dus;

  ecer_unit_mem u_mem (
    .clk(clk),
    .rstn(rstn),
    .rd_en(mem_re),
    .rd_idx(mem_ridx),
    .rd_data(mem_rd),
    .wr_en(mem_we),
    .wr_idx(mem_widx),
    .wr_data(mem_wd)
  );

  assign so = s_reg.so;
  assign so_oe_n = s_reg.so_oe_n;
  assign prog_err = s_reg.prog_err;

  // register value for a read; unmapped addresses give zero
  function automatic logic [31:0] reg_value(input logic [31:0] ra, input ecer_state_s st);
    logic [31:0] v;
    v = '0;
    case (ra)
      ECER_RA_STATUS: v = {st.status & ECER_STAT_USED, 24'h00_0000};
      ECER_RA_TRAP: v = st.trap;
      ECER_RA_TALLY: v = {st.tally, 16'h0000};
      default: v = '0;
    endcase
    return v;
  endfunction

  // ***********************************************************
  // next-state logic
  // ***********************************************************
  always_comb
  begin
    s_next = s_reg;
    s_next.prog_err = 1'b0;
    s_next.q_pend = 1'b0;
    s_next.pend_v = 1'b0;
    s_next.prog_v = 1'b0;
    mem_re = 1'b0;
    mem_we = 1'b0;
    mem_ridx = '0;
    mem_widx = '0;
    mem_wd = '0;
    f_upd = mem_rd;
    clr_cmd = 1'b0;
    op = '0;
    a = '0;
    dus = ECER_DUS_RST;
    e1 = 1'b0;
    e2 = 1'b0;
    err = 1'b0;
    dup = 1'b0;

    // pins pass two flops; edge detect reads stages 1 and 2 only
    s_next.sck_s = {s_reg.sck_s[1:0], sck};
    s_next.cs_s = {s_reg.cs_s[1:0], cs_n};
    s_next.si_s = {s_reg.si_s[0], si};
    sck_rise = s_reg.sck_s[1] & ~s_reg.sck_s[2];
    sck_fall = ~s_reg.sck_s[1] & s_reg.sck_s[2];
    cs_fall = ~s_reg.cs_s[1] & s_reg.cs_s[2];
    cs_rise = s_reg.cs_s[1] & ~s_reg.cs_s[2];

    // serial command decode, mode 0, msb first
    if (cs_rise)
    begin
      clr_cmd = s_reg.clr_armed; // clear acts when the command completes
      s_next.phase = ECER_SP_IDLE;
      s_next.clr_armed = 1'b0;
      s_next.so_oe_n = 1'b1;
      s_next.so = 1'b0;
    end
    else if (cs_fall)
    begin
      s_next.phase = ECER_SP_OP;
      s_next.bit_cnt = '0;
    end
    else
    begin
      case (s_reg.phase)
        ECER_SP_OP:
        begin
          if (sck_rise)
          begin
            s_next.sh_in = {s_reg.sh_in[30:0], s_reg.si_s[1]};
            s_next.bit_cnt = s_reg.bit_cnt + ECER_CNT_ONE;
            if (s_reg.bit_cnt == ECER_OP_LAST)
            begin
              op = {s_reg.sh_in[6:0], s_reg.si_s[1]};
              s_next.bit_cnt = '0;
              s_next.is_query = (op == ECER_OP_UNIT_QUERY);
              if (op == ECER_OP_REG_READ || op == ECER_OP_UNIT_QUERY)
              begin
                s_next.phase = ECER_SP_ADDR;
              end
              else
              begin
                s_next.clr_armed = (op == ECER_OP_CLEAR);
                s_next.phase = ECER_SP_WAIT; // unknown opcodes are ignored
              end
            end
          end
        end
        ECER_SP_ADDR:
        begin
          if (sck_rise)
          begin
            s_next.sh_in = {s_reg.sh_in[30:0], s_reg.si_s[1]};
            s_next.bit_cnt = s_reg.bit_cnt + ECER_CNT_ONE;
            if (s_reg.bit_cnt == ECER_ADDR_LAST)
            begin
              a = {s_reg.sh_in[30:0], s_reg.si_s[1]};
              s_next.bit_cnt = '0;
              s_next.phase = ECER_SP_OUT;
              if (s_reg.is_query)
              begin
                mem_re = 1'b1;
                mem_ridx = a[ECER_UNIT_LO +: ECER_IDX_W];
                s_next.q_pend = 1'b1;
              end
              else
              begin
                s_next.sh_out = reg_value(a, s_reg); // no state is touched
              end
            end
          end
        end
        ECER_SP_OUT:
        begin
          if (sck_fall)
          begin
            s_next.so = s_reg.sh_out[31];
            s_next.sh_out = {s_reg.sh_out[30:0], 1'b0};
            s_next.so_oe_n = 1'b0;
          end
        end
        ECER_SP_IDLE, ECER_SP_WAIT:
        begin
          s_next.phase = s_reg.phase;
        end
        default:
        begin
          s_next.phase = ECER_SP_IDLE;
        end
      endcase
    end

    // unit status byte; double-bit flag reads zero when detection is off
    if (s_reg.q_pend)
    begin
      dus[ECER_DUS_DBE_BIT] = mem_rd.dbe & dbl_detect_en;
      dus[ECER_DUS_SBC_BIT] = mem_rd.sbe;
      dus[ECER_DUS_OFF_BIT] = mem_rd.off;
      s_next.sh_out = {dus, 24'h00_0000};
    end

    // event sources fetch the unit flags; engines never overlap
    if (unit_valid && arr_rd_active)
    begin
      mem_re = 1'b1;
      mem_ridx = unit_in.addr[ECER_UNIT_LO +: ECER_IDX_W];
      s_next.pend = unit_in;
      s_next.pend_v = 1'b1;
    end
    else if (prog_req)
    begin
      mem_re = 1'b1;
      mem_ridx = prog_addr[ECER_UNIT_LO +: ECER_IDX_W];
      s_next.pend.addr = prog_addr;
      s_next.prog_v = 1'b1;
    end

    // clears first, so an event in the same cycle still lands
    clr_any = hw_sw_reset | serial_reset | clr_cmd;
    if (clr_any)
    begin
      s_next.status = ECER_STAT_RST;
      s_next.trap = ECER_TRAP_RST;
      s_next.trap_full = 1'b0;
      s_next.tally = ECER_TALLY_RST;
    end

    // evaluate one decoded unit against its flags
    if (s_reg.pend_v)
    begin
      e2 = s_reg.pend.dbe & dbl_detect_en & ~mem_rd.off;
      e1 = s_reg.pend.sbe & ~mem_rd.off & ~e2;
      err = e1 | e2;
      dup = s_reg.last_v &&
            (s_reg.last_unit[31:ECER_UNIT_LO] == s_reg.pend.addr[31:ECER_UNIT_LO]);
      s_next.status[ECER_STAT_SBE_BIT] = s_next.status[ECER_STAT_SBE_BIT] | e1;
      s_next.status[ECER_STAT_DBE_BIT] = s_next.status[ECER_STAT_DBE_BIT] | e2;
      if (err && !s_next.trap_full && (e2 || trap_any_err))
      begin
        s_next.trap = s_reg.pend.addr;
        s_next.trap_full = 1'b1;
      end
      if (err && s_reg.pend.main_arr && !dup && s_next.tally != ECER_TALLY_MAX)
      begin
        s_next.tally = s_next.tally + ECER_TALLY_ONE;
      end
      s_next.last_v = 1'b1;
      s_next.last_unit = s_reg.pend.addr;
      f_upd.sbe = e1;
      f_upd.dbe = e2;
      mem_we = 1'b1;
      mem_widx = s_reg.pend.addr[ECER_UNIT_LO +: ECER_IDX_W];
      mem_wd = f_upd;
    end
    else if (s_reg.prog_v)
    begin
      mem_widx = s_reg.pend.addr[ECER_UNIT_LO +: ECER_IDX_W];
      if (mem_rd.programmed && dbl_detect_en)
      begin
        s_next.prog_err = 1'b1;
      end
      else
      begin
        f_upd.off = mem_rd.programmed; // second program turns checking off
        f_upd.programmed = 1'b1;
        mem_we = 1'b1;
        mem_wd = f_upd;
      end
    end
    else if (erase_req)
    begin
      mem_we = 1'b1;
      mem_widx = erase_addr[ECER_UNIT_LO +: ECER_IDX_W];
      mem_wd = '0;
    end

    // a new transaction may count the same unit again
    if (!arr_rd_active)
    begin
      s_next.last_v = 1'b0;
    end
  end

  // ***********************************************************
  // state register
  // ***********************************************************
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      s_reg <= '0;
      s_reg.cs_s <= 3'b111;
      s_reg.sck_s <= 3'b000;
      s_reg.so_oe_n <= 1'b1;
      s_reg.status <= ECER_STAT_RST;
      s_reg.trap <= ECER_TRAP_RST;
      s_reg.tally <= ECER_TALLY_RST;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ***********************************************************
  // checks
  // ***********************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  stat_rsvd_zero_a: assert property ((s_reg.status & ~ECER_STAT_USED) == 8'h00)
    else $error("reserved status bits set");
  tally_saturate_a: assert property (
    (s_reg.tally == ECER_TALLY_MAX && !clr_any) |=> s_reg.tally == ECER_TALLY_MAX)
    else $error("tally wrapped");
  tally_step_a: assert property (
    !clr_any |=> (s_reg.tally == $past(s_reg.tally) ||
                  s_reg.tally == $past(s_reg.tally) + ECER_TALLY_ONE))
    else $error("tally moved by more than one");
  tally_rd_only_a: assert property (
    (!$stable(s_reg.tally) && s_reg.tally != ECER_TALLY_RST) |-> $past(s_reg.pend_v))
    else $error("tally changed outside array read");
  trap_hold_a: assert property ((s_reg.trap_full && !clr_any) |=> $stable(s_reg.trap))
    else $error("trap overwritten");
  trap_valid_a: assert property (
    s_reg.trap_full |-> (s_reg.status[ECER_STAT_SBE_BIT] | s_reg.status[ECER_STAT_DBE_BIT]))
    else $error("trap valid without status bit");
  trap_rd_only_a: assert property (
    (!$stable(s_reg.trap) && s_reg.trap_full) |-> $past(s_reg.pend_v))
    else $error("trap changed outside array read");
  clear_all_a: assert property (
    (clr_any && !s_reg.pend_v) |=>
      (s_reg.status == ECER_STAT_RST && s_reg.tally == ECER_TALLY_RST && !s_reg.trap_full))
    else $error("clear incomplete");
  off_no_count_a: assert property (
    (s_reg.pend_v && mem_rd.off && !clr_any) |=> $stable(s_reg.tally))
    else $error("counted unit with checking off");
  dup_no_count_a: assert property ((s_reg.pend_v && dup && !clr_any) |=> $stable(s_reg.tally))
    else $error("unit counted twice in one read");
  reprog_err_a: assert property (
    (s_reg.prog_v && mem_rd.programmed && dbl_detect_en) |=> s_reg.prog_err)
    else $error("missing program error");

  tally_full_c: cover property (s_reg.tally == ECER_TALLY_MAX);
  trap_taken_c: cover property (!s_reg.trap_full ##1 s_reg.trap_full);
  query_done_c: cover property (s_reg.q_pend ##[1:40] !s_reg.so_oe_n);
  prog_err_c: cover property (s_reg.prog_err);

endmodule

// >>> sim/ecer_host_model.sv
`timescale 1ns/1ps
module ecer_host_model
  import ecer_pkg::*;
(
  // bench clock
  input wire logic clk,
  // serial pins
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  // ***********************************************************
  // idle pins: sck parked low outside frames
  // ***********************************************************
  initial
  begin
    sck = 1'h0;
    cs_n = 1'h1;
    si = 1'h0;
  end

  // one frame at 160 ns per bit: opcode, optional address, nrd bits back
  task automatic xfer(input logic [7:0] op, input bit adr, input logic [31:0] a,
                      input int nrd, output logic [31:0] rd);
    logic [39:0] tx;
    int nin;
    tx = {op, a};
    nin = adr ? 40 : 8;
    rd = '0;
    @(negedge clk);
    cs_n = 1'h0;
    repeat (10) @(negedge clk);
    for (int i = 0; i < nin + nrd; i++)
    begin
      if (i < nin) si = tx[39-i];
      repeat (10) @(negedge clk);
      sck = 1'h1;
      // so moved 3 clk after the last fall, long settled here
      if (i >= nin) rd = {rd[30:0], so};
      repeat (10) @(negedge clk);
      sck = 1'h0;
    end
    repeat (10) @(negedge clk);
    cs_n = 1'h1;
    // released line flips so stale data is never mistaken for held data
    si = ~si;
    repeat (10) @(negedge clk);
  endtask
endmodule

// >>> sim/testbench.sv
`timescale 1ns/1ps
module testbench
  import ecer_pkg::*;
;
  logic clk, rstn, sck, cs_n, si, so, so_oe_n, arr_rd_active, unit_valid;
  ecer_unit_s unit_in;
  logic prog_req, erase_req, prog_err, dbl_detect_en, trap_any_err;
  logic hw_sw_reset, serial_reset;
  logic [31:0] prog_addr, erase_addr;
  int err_total, tests_run, perr_seen, oe_low;

  // ***********************************************************
  // clock, block and host
  // ***********************************************************
  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  ecer_top u_dut (.clk(clk), .rstn(rstn), .sck(sck), .cs_n(cs_n), .si(si), .so(so),
    .so_oe_n(so_oe_n), .arr_rd_active(arr_rd_active), .unit_valid(unit_valid),
    .unit_in(unit_in), .prog_req(prog_req), .prog_addr(prog_addr), .erase_req(erase_req),
    .erase_addr(erase_addr), .prog_err(prog_err), .dbl_detect_en(dbl_detect_en),
    .trap_any_err(trap_any_err), .hw_sw_reset(hw_sw_reset), .serial_reset(serial_reset));

  ecer_host_model u_host (.clk(clk), .sck(sck), .cs_n(cs_n), .si(si), .so(so));

  // program errors are single-cycle pulses, so count them as they pass
  always @(posedge clk)
    if (prog_err === 1'h1) perr_seen++;

  // cycles in which the block drives so; ignored opcodes must leave it released
  always @(posedge clk)
    if (so_oe_n !== 1'h1) oe_low++;

  // ***********************************************************
  // shared tasks
  // ***********************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd3(input logic [7:0] s, input logic [31:0] t, input logic [15:0] c);
    logic [31:0] r;
    u_host.xfer(ECER_OP_REG_READ, 1'h1, ECER_RA_STATUS, 8, r);
    chk(r, {24'h0, s});
    u_host.xfer(ECER_OP_REG_READ, 1'h1, ECER_RA_TRAP, 32, r);
    chk(r, t);
    u_host.xfer(ECER_OP_REG_READ, 1'h1, ECER_RA_TALLY, 16, r);
    chk(r, {16'h0, c});
  endtask

  task automatic query(input logic [31:0] a, input logic [7:0] e);
    logic [31:0] r;
    u_host.xfer(ECER_OP_UNIT_QUERY, 1'h1, a, 8, r);
    chk(r, {24'h0, e});
  endtask

  task automatic clr();
    logic [31:0] r;
    u_host.xfer(ECER_OP_CLEAR, 1'h0, 32'h0, 0, r);
  endtask

  // one unit, then an idle cycle so the same flag index never follows itself
  task automatic unit(input logic [31:0] a, input logic s, input logic d, input logic m);
    @(negedge clk);
    unit_valid = 1'h1;
    unit_in = {a, s, d, m};
    @(negedge clk);
    unit_valid = 1'h0;
    @(negedge clk);
  endtask

  task automatic pe(input logic er, input logic [31:0] a);
    @(negedge clk);
    prog_req = ~er;
    erase_req = er;
    prog_addr = a;
    erase_addr = a;
    @(negedge clk);
    prog_req = 1'h0;
    erase_req = 1'h0;
    repeat (4) @(negedge clk);
  endtask

  // ***********************************************************
  // scenarios
  // ***********************************************************
  task automatic t_reset();
    logic [31:0] r;
    oe_low = 0;
    chk(so_oe_n, 32'h1);
    // opcode the block does not decode: no answer, line stays released
    u_host.xfer(8'h5A, 1'h0, 32'h0, 8, r);
    chk(r, 32'h0);
    chk(oe_low, 32'h0);
    rd3(8'h00, 32'h0, 16'h0);
    chk(oe_low != 0, 32'h1);
    chk(so_oe_n, 32'h1);
    u_host.xfer(ECER_OP_REG_READ, 1'h1, 32'h0000_0200, 32, r);
    chk(r, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_basic();
    unit(32'h0000_0500, 1'h1, 1'h1, 1'h1);  // read engine idle: must be ignored
    arr_rd_active = 1'h1;
    unit(32'h0000_1234, 1'h1, 1'h0, 1'h1);
    unit(32'h0000_1238, 1'h1, 1'h0, 1'h1);
    unit(32'h0000_1250, 1'h0, 1'h1, 1'h1);
    unit(32'h0000_1260, 1'h1, 1'h0, 1'h0);
    arr_rd_active = 1'h0;
    @(negedge clk);
    arr_rd_active = 1'h1;
    unit(32'h0000_1250, 1'h0, 1'h1, 1'h1);
    arr_rd_active = 1'h0;
    rd3(8'h18, 32'h0000_1234, 16'h0003);
    query(32'h0000_1234, 8'h02);
    query(32'h0000_1250, 8'h08);
    rd3(8'h18, 32'h0000_1234, 16'h0003);
    $display("test basic done");
  endtask

  task automatic t_type();
    clr();
    trap_any_err = 1'h0;
    arr_rd_active = 1'h1;
    unit(32'h0000_2000, 1'h1, 1'h0, 1'h1);
    unit(32'h0000_2040, 1'h0, 1'h1, 1'h1);
    unit(32'h0000_2080, 1'h0, 1'h1, 1'h1);
    arr_rd_active = 1'h0;
    rd3(8'h18, 32'h0000_2040, 16'h0003);
    trap_any_err = 1'h1;
    $display("test trap type done");
  endtask

  task automatic t_clear();
    for (int k = 0; k < 3; k++)
    begin
      arr_rd_active = 1'h1;
      unit(32'h0000_3000, 1'h0, 1'h1, 1'h1);
      arr_rd_active = 1'h0;
      if (k == 0) clr();
      hw_sw_reset = (k == 1);
      serial_reset = (k == 2);
      @(negedge clk);
      hw_sw_reset = 1'h0;
      serial_reset = 1'h0;
      rd3(8'h00, 32'h0, 16'h0);
    end
    $display("test clear done");
  endtask

  task automatic t_sat();
    logic [31:0] r;
    arr_rd_active = 1'h1;
    // back-to-back units, each flag index differing from the one before, to reach the ceiling fast
    for (int i = 0; i < 65535; i++)
    begin
      @(negedge clk);
      unit_valid = 1'h1;
      unit_in = {i[27:0], 4'h0, 1'h1, 1'h0, 1'h1};
    end
    @(negedge clk);
    unit_valid = 1'h0;
    u_host.xfer(ECER_OP_REG_READ, 1'h1, ECER_RA_TALLY, 16, r);
    chk(r, 32'h0000_FFFF);
    unit(32'h0000_0010, 1'h0, 1'h1, 1'h1);
    arr_rd_active = 1'h0;
    u_host.xfer(ECER_OP_REG_READ, 1'h1, ECER_RA_TALLY, 16, r);
    chk(r, 32'h0000_FFFF);
    $display("test saturation done");
  endtask

  task automatic t_reprog();
    clr();
    dbl_detect_en = 1'h1;
    pe(1'h1, 32'h0000_4010);
    pe(1'h0, 32'h0000_4010);
    pe(1'h0, 32'h0000_4010);
    chk(perr_seen, 1);
    dbl_detect_en = 1'h0;
    pe(1'h1, 32'h0000_5020);
    pe(1'h0, 32'h0000_5020);
    pe(1'h0, 32'h0000_5020);
    chk(perr_seen, 1);
    query(32'h0000_5020, 8'h01);
    arr_rd_active = 1'h1;
    unit(32'h0000_5020, 1'h1, 1'h0, 1'h1);
    arr_rd_active = 1'h0;
    rd3(8'h00, 32'h0, 16'h0);
    pe(1'h1, 32'h0000_5020);
    query(32'h0000_5020, 8'h00);
    $display("test reprogram done");
  endtask

  // ***********************************************************
  // run control
  // ***********************************************************
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // watchdog: the full run needs roughly 104k cycles, mostly the saturation fill
  initial
  begin
    repeat (115000) @(posedge clk);
    err_total++;
    finish_test();
  end

  initial
  begin
    {rstn, arr_rd_active, unit_valid, prog_req, erase_req} = '0;
    {hw_sw_reset, serial_reset, trap_any_err} = 3'h1;
    dbl_detect_en = 1'h1;
    unit_in = '0;
    prog_addr = 32'h0;
    erase_addr = 32'h0;
    err_total = 0;
    tests_run = 0;
    perr_seen = 0;
    oe_low = 0;
    repeat (20) @(negedge clk);
    rstn = 1'h1;
    repeat (5) @(negedge clk);
    t_reset();
    t_basic();
    t_type();
    t_clear();
    t_sat();
    t_reprog();
    finish_test();
  end
endmodule
